// ==== rtl/lpm_pkg.sv ====
// Package of constants and types for the low power mode controller.
package lpm_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned POR_HOLD_MS    = 128;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned OSC_START_US   = 10;
  localparam int unsigned OSC_START_CYC  = OSC_START_US * CLK_MHZ;
  localparam int unsigned PLL_LOCK_US    = 20;
  localparam int unsigned PLL_LOCK_CYC   = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned MACH_CYC_CLKS  = 12;
  localparam int unsigned EXT0_GUARD_MC  = 2;
  localparam int unsigned EXT0_GUARD_CYC = EXT0_GUARD_MC * MACH_CYC_CLKS;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_POWER_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_PLL_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h4;

  // Power control register fields.
  localparam int PC_IDLE       = 0;
  localparam int PC_PDOWN      = 1;
  localparam int PC_SERIAL_WK  = 2;
  localparam int PC_EXT0_WK    = 3;
  localparam int PC_TIC_KEEP   = 4;
  localparam logic [7:0] POWER_CTRL_RST = 8'h00;

  // Pll control register fields.
  localparam int PLL_OSC_SHUT  = 0;
  localparam logic [7:0] PLL_CTRL_RST = 8'h00;

  // Interrupt status / mask bits.
  localparam int EV_IDLE_WAKE  = 0;
  localparam int EV_PD_WAKE    = 1;
  localparam int EV_EXT0_GUARD = 2;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_IDLE,
    ST_PDOWN,
    ST_OSC_WAIT,
    ST_PLL_WAIT
  } pwr_state_e;

endpackage

// ==== rtl/wake_if.sv ====
// Interface carrying synchronised wake sources to the wake qualifier.
`timescale 1ns/1ps
interface wake_if;
  logic enabled_irq;
  logic tic_irq;
  logic serial_irq;
  logic ext0_low;
  logic serial_wk_en;
  logic ext0_wk_en;
  logic in_idle;
  logic in_pdown;
  logic wake_idle;
  logic wake_pdown;

  modport ctrl (output enabled_irq, tic_irq, serial_irq, ext0_low,
                output serial_wk_en, ext0_wk_en, in_idle, in_pdown,
                input  wake_idle, wake_pdown);
  modport qual (input  enabled_irq, tic_irq, serial_irq, ext0_low,
                input  serial_wk_en, ext0_wk_en, in_idle, in_pdown,
                output wake_idle, wake_pdown);
endinterface

// ==== rtl/wake_qualifier.sv ====
// Combines wake sources with their enables into idle and power-down wakes.
`timescale 1ns/1ps
module wake_qualifier
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wake sources
  wake_if.qual     wk
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk.wake_idle  <= 1'b0;
      wk.wake_pdown <= 1'b0;
    end else begin
      wk.wake_idle  <= wk.in_idle & wk.enabled_irq;
      wk.wake_pdown <= wk.in_pdown & (wk.tic_irq
                     | (wk.serial_irq & wk.serial_wk_en)
                     | (wk.ext0_low & wk.ext0_wk_en));
    end
  end

endmodule

// ==== rtl/low_power_mode_controller.sv ====
// Top of the low power mode controller: modes, clocks, wake and reset hold.
//
// Functional notes
// - Software write moves the chip into idle or full power-down.
// - Idle keeps oscillator running, stops core clock, peripherals keep clocks.
// - Idle preserves core state; port and converter outputs hold.
// - Any enabled interrupt or hardware reset ends idle.
// - Full power-down stops both PLL and core clock.
// - Oscillator stops in power-down only if shutdown bit is set.
// - Interval counter may run in power-down; other peripherals stop.
// - Power-down holds port levels; converter outputs go high impedance.
// - Reset during power-down returns to normal with default registers.
// - After power cycling, defaults and reset vector about 128 ms later.
// - Interval counter interrupt ends power-down only with its keep bit set; resume after entry.
// - Serial interrupt ends power-down only with serial wake enable.
// - External interrupt 0 ends power-down only with its wake enable.
// - Power-on reset holds while supply low, then about 128 ms timer.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_HOLD_CYC
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Supply monitor and pins
  input  wire logic       supply_ok,
  input  wire logic       external_interrupt_zero_n,
  // Interrupt sources from peripherals and core
  input  wire logic       enabled_irq_pending,
  input  wire logic       interval_counter_irq,
  input  wire logic       serial_irq,
  input  wire logic       return_from_interrupt,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Clock and power controls
  output logic            osc_enable,
  output logic            pll_enable,
  output logic            core_clk_enable,
  output logic            periph_clk_enable,
  output logic            interval_counter_clk_enable,
  output logic            port_hold,
  output logic            dac_out_oe,
  output logic            core_reset,
  output logic            wake_irq_service,
  output logic            irq
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] sync_supply;
  logic [1:0] sync_ext0;
  logic       supply_s;
  logic       ext0_low_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_supply <= 2'b00;
      sync_ext0   <= 2'b11;
    end else begin
      sync_supply <= {sync_supply[0], supply_ok};
      sync_ext0   <= {sync_ext0[0], external_interrupt_zero_n};
    end
  end
  assign supply_s   = sync_supply[1];
  assign ext0_low_s = ~sync_ext0[1];

  // ------------------------------------------------------------------
  // Power-on reset hold
  // ------------------------------------------------------------------
  // The hold counts only while the supply stays up; a dip restarts it.
  logic [31:0] por_cnt;
  logic        por_active;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else if (!supply_s) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else if (por_cnt < POR_CYCLES) begin
      por_cnt    <= por_cnt + 32'h1;
      por_active <= 1'b1;
    end else begin
      por_active <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0]  power_control_register;
  logic [7:0]  pll_control_register;
  logic [7:0]  irq_status;
  logic [7:0]  irq_mask;
  pwr_state_e  state;
  pwr_state_e  next_state;
  logic [15:0] wait_cnt;
  logic [7:0]  ext0_guard_cnt;
  logic        enter_idle;
  logic        enter_pdown;
  logic        guard_violation;
  logic        pc_write;
  logic        next_tic_keep;
  logic [7:0]  ev_set;

  wake_if wk ();

  // Mode writes are refused while the reset hold runs, like the register
  // write itself, so the outputs never leave their normal values early.
  assign pc_write      = reg_wr && !por_active &&
                         reg_addr == ADDR_POWER_CTRL;
  assign enter_idle    = pc_write && reg_wdata[PC_IDLE] &&
                         !reg_wdata[PC_PDOWN];
  assign enter_pdown   = pc_write && reg_wdata[PC_PDOWN];

  // The keep bit as it will stand after this edge, so the interval
  // counter clock does not drop for a cycle on entry to power-down.
  assign next_tic_keep = pc_write ? reg_wdata[PC_TIC_KEEP] :
                         power_control_register[PC_TIC_KEEP];

  // Mode bits are self-clearing on wake, so software reading back sees the
  // mode it is actually in.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control_register <= POWER_CTRL_RST;
    end else if (por_active) begin
      power_control_register <= POWER_CTRL_RST;
    end else if (reg_wr && reg_addr == ADDR_POWER_CTRL) begin
      power_control_register <= reg_wdata;
    end else if (wk.wake_idle || wk.wake_pdown) begin
      power_control_register[PC_IDLE]  <= 1'b0;
      power_control_register[PC_PDOWN] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_control_register <= PLL_CTRL_RST;
    end else if (por_active) begin
      pll_control_register <= PLL_CTRL_RST;
    end else if (reg_wr && reg_addr == ADDR_PLL_CTRL) begin
      pll_control_register <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_NORMAL: begin
        if (enter_pdown) begin
          next_state = ST_PDOWN;
        end else if (enter_idle) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wk.wake_idle) begin
          next_state = ST_NORMAL;
        end
      end
      ST_PDOWN: begin
        if (wk.wake_pdown) begin
          next_state = pll_control_register[PLL_OSC_SHUT] ?
                       ST_OSC_WAIT : ST_PLL_WAIT;
        end
      end
      ST_OSC_WAIT: begin
        if (wait_cnt == 16'h0) begin
          next_state = ST_PLL_WAIT;
        end
      end
      ST_PLL_WAIT: begin
        if (wait_cnt == 16'h0) begin
          next_state = ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_NORMAL;
    end else if (por_active) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 16'h0;
    end else if (state == ST_PDOWN && next_state == ST_OSC_WAIT) begin
      wait_cnt <= 16'(OSC_START_CYC - 1);
    end else if (next_state == ST_PLL_WAIT && state != ST_PLL_WAIT) begin
      wait_cnt <= 16'(PLL_LOCK_CYC - 1);
    end else if (wait_cnt != 16'h0) begin
      wait_cnt <= wait_cnt - 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // Wake qualification
  // ------------------------------------------------------------------
  assign wk.enabled_irq  = enabled_irq_pending;
  assign wk.tic_irq      = interval_counter_irq &
                           power_control_register[PC_TIC_KEEP];
  assign wk.serial_irq   = serial_irq;
  assign wk.ext0_low     = ext0_low_s;
  assign wk.serial_wk_en = power_control_register[PC_SERIAL_WK];
  assign wk.ext0_wk_en   = power_control_register[PC_EXT0_WK];
  assign wk.in_idle      = state == ST_IDLE;
  assign wk.in_pdown     = state == ST_PDOWN;

  wake_qualifier u_wake_qualifier (
    .clk (clk),
    .rst (rst),
    .wk  (wk.qual)
  );

  // External interrupt 0 low near power-down entry is flagged; it still wakes if its wake enable is set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext0_guard_cnt <= 8'h0;
    end else if (enter_pdown && state == ST_NORMAL) begin
      ext0_guard_cnt <= 8'(EXT0_GUARD_CYC);
    end else if (ext0_guard_cnt != 8'h0) begin
      ext0_guard_cnt <= ext0_guard_cnt - 8'h1;
    end
  end
  assign guard_violation = ext0_guard_cnt != 8'h0 && ext0_low_s;

  // ------------------------------------------------------------------
  // Clock, pin and reset controls
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_enable                  <= 1'b1;
      pll_enable                  <= 1'b1;
      core_clk_enable             <= 1'b0;
      periph_clk_enable           <= 1'b0;
      interval_counter_clk_enable <= 1'b1;
      port_hold                   <= 1'b0;
      dac_out_oe                  <= 1'b0;
      core_reset                  <= 1'b1;
    end else begin
      core_reset      <= por_active;
      osc_enable      <= !(next_state == ST_PDOWN &&
                           pll_control_register[PLL_OSC_SHUT]);
      pll_enable      <= next_state == ST_NORMAL ||
                         next_state == ST_IDLE ||
                         next_state == ST_PLL_WAIT;
      core_clk_enable <= !por_active &&
                         next_state == ST_NORMAL;
      periph_clk_enable <= next_state == ST_NORMAL ||
                           next_state == ST_IDLE;
      interval_counter_clk_enable <= next_state != ST_PDOWN ||
                                     next_tic_keep;
      port_hold       <= next_state != ST_NORMAL;
      dac_out_oe      <= !por_active &&
                         next_state != ST_PDOWN &&
                         next_state != ST_OSC_WAIT &&
                         next_state != ST_PLL_WAIT;
    end
  end

  // Core services the interrupt that ended power-down; its return resumes after entry.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_irq_service <= 1'b0;
    end else if (state == ST_PLL_WAIT && next_state == ST_NORMAL) begin
      wake_irq_service <= 1'b1;
    end else if (return_from_interrupt || por_active) begin
      wake_irq_service <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status, mask and read port
  // ------------------------------------------------------------------
  always_comb begin
    ev_set                = 8'h00;
    ev_set[EV_IDLE_WAKE]  = wk.wake_idle;
    ev_set[EV_PD_WAKE]    = wk.wake_pdown;
    ev_set[EV_EXT0_GUARD] = guard_violation;
  end

  // Set beats clear so an event in the clearing cycle is kept.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= 8'h00;
    end else if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~reg_wdata) | ev_set;
    end else begin
      irq_status <= irq_status | ev_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_POWER_CTRL: reg_rdata <= power_control_register;
        ADDR_PLL_CTRL:   reg_rdata <= pll_control_register;
        ADDR_STATUS:     reg_rdata <= {5'h00, state};
        ADDR_IRQ_STATUS: reg_rdata <= irq_status;
        ADDR_IRQ_MASK:   reg_rdata <= irq_mask;
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ==== testbench/lpm_properties.sv ====
// Port-level checks for the low power mode controller.
`timescale 1ns/1ps
module lpm_properties
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Core and register port
  input wire logic       return_from_interrupt,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Clock and power controls
  input wire logic       osc_enable,
  input wire logic       pll_enable,
  input wire logic       core_clk_enable,
  input wire logic       periph_clk_enable,
  input wire logic       port_hold,
  input wire logic       dac_out_oe,
  input wire logic       core_reset,
  input wire logic       wake_irq_service
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pd_entry_stop: assert property (reg_wr && reg_addr == 4'h0 &&
    reg_wdata[1] && core_clk_enable |-> ##[1:2] !pll_enable)
    else $error("power-down write did not stop the pll");
  a_pll_core_off: assert property (!pll_enable |-> !core_clk_enable)
    else $error("core clock runs without the pll");
  a_pd_dac_hiz: assert property (!pll_enable |-> !dac_out_oe)
    else $error("converter outputs driven in power-down");
  a_osc_pll_off: assert property (!osc_enable |-> !pll_enable &&
    !periph_clk_enable)
    else $error("oscillator stopped while clocks run");
  a_ports_frozen: assert property (!core_clk_enable && !core_reset
    |-> port_hold)
    else $error("ports not held while core stopped");
  a_idle_clocks: assert property (periph_clk_enable && port_hold
    |-> osc_enable && !core_clk_enable && dac_out_oe)
    else $error("idle clock or output state wrong");
  a_core_periph_on: assert property (core_clk_enable
    |-> periph_clk_enable)
    else $error("peripherals stopped while core runs");
  a_core_after_pll: assert property ($rose(core_clk_enable)
    |-> osc_enable && pll_enable && $past(pll_enable))
    else $error("core clock resumed before stable clock");
  a_wake_service: assert property ($rose(wake_irq_service)
    |-> ##[0:2] core_clk_enable)
    else $error("wake service without running core");
  a_return_ends: assert property (wake_irq_service &&
    return_from_interrupt |=> !wake_irq_service)
    else $error("return did not end wake service");
  a_por_hold: assert property (core_reset |-> !core_clk_enable)
    else $error("core clock runs during reset hold");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind low_power_mode_controller lpm_properties chk (.clk, .rst,
  .return_from_interrupt, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .osc_enable, .pll_enable, .core_clk_enable,
  .periph_clk_enable, .port_hold, .dac_out_oe, .core_reset,
  .wake_irq_service);

// ==== testbench/core_partner.sv ====
// Core software and wake pin model facing the controller.
`timescale 1ns/1ps
module core_partner (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Controls from the bench
  input wire logic [3:0] ret_delay,
  input wire logic       ext0_req,
  // Controller side
  input wire logic       wake_irq_service,
  output logic           return_from_interrupt,
  output logic           external_interrupt_zero_n
);
  logic [3:0] cnt;

  // The pin has a pull-up, so a released pin reads high.
  assign external_interrupt_zero_n = !ext0_req;

  // The handler runs a while before its return, never at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt                   <= 4'h0;
      return_from_interrupt <= 1'b0;
    end else begin
      return_from_interrupt <= 1'b0;
      if (!wake_irq_service || return_from_interrupt) begin
        cnt <= 4'h0;
      end else if (cnt == ret_delay) begin
        return_from_interrupt <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ==== testbench/low_power_mode_controller_tb.sv ====
// Self-checking bench for the low power mode controller.
`timescale 1ns/1ps
module low_power_mode_controller_tb;
  import lpm_pkg::*;
  logic clk = 0, rst = 1, supply_ok = 0, enabled_irq_pending = 0;
  logic interval_counter_irq = 0, serial_irq = 0, ext0_req = 0;
  logic reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic [3:0] reg_addr = 4'h0, ret_delay = 4'h3;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_q[$];
  logic osc_enable, pll_enable, core_clk_enable, periph_clk_enable;
  logic interval_counter_clk_enable, port_hold, dac_out_oe, core_reset;
  logic wake_irq_service, irq, return_from_interrupt;
  logic external_interrupt_zero_n;
  logic [31:0] seed = 32'd52820;
  int err_total = 0, num_checks = 0, n;

  always #4 clk = !clk;

  low_power_mode_controller #(.POR_CYCLES(50)) DUT (.clk, .rst, .supply_ok,
    .external_interrupt_zero_n, .enabled_irq_pending,
    .interval_counter_irq, .serial_irq, .return_from_interrupt, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_enable, .pll_enable,
    .core_clk_enable, .periph_clk_enable, .interval_counter_clk_enable,
    .port_hold, .dac_out_oe, .core_reset, .wake_irq_service, .irq);
  core_partner partner (.clk, .rst, .ret_delay, .ext0_req,
    .wake_irq_service, .return_from_interrupt, .external_interrupt_zero_n);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen) check(reg_rdata, exp_q.pop_front());

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    check(core_reset, 1);
    rst <= 1'b0;
    supply_ok <= 1'b1;
    repeat (10) @(posedge clk);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    repeat (30) @(posedge clk);
    check(core_reset, 1);
    repeat (30) @(posedge clk);
    check(core_reset, 0);
    rd(4'h2, 8'h00);
  endtask

  // A wake is bounded; a hang here counts as a mismatch.
  task automatic wake_wait();
    n = 0;
    while (core_clk_enable !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n == 6000) check(8'h00, 8'h01);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(8 * 40000);
    err_total++;
    wrap_up();
  end

  initial begin
    @(posedge clk);
    do_reset();
    wr(4'h5 + 4'(rnd() % 11), 8'(rnd()));
    rd(4'h5 + 4'(rnd() % 11), 8'h00);
    done("reset and map");
    wr(4'h0, 8'h01);
    check({osc_enable, periph_clk_enable, core_clk_enable}, 3'b110);
    check({port_hold, dac_out_oe}, 2'b11);
    rd(4'h2, 8'h01);
    wr(4'h4, 8'h01);
    enabled_irq_pending <= 1'b1;
    repeat (4) @(posedge clk);
    enabled_irq_pending <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h01);
    rd(4'h0, 8'h00);
    check(irq, 1);
    wr(4'h3, 8'h01);
    @(posedge clk);
    check(irq, 0);
    done("idle");
    ret_delay <= 4'(rnd());
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h1e);
    check({pll_enable, core_clk_enable, osc_enable}, 3'b000);
    check({periph_clk_enable, interval_counter_clk_enable}, 2'b01);
    check({port_hold, dac_out_oe}, 2'b10);
    rd(4'h2, 8'h02);
    serial_irq <= 1'b1;
    wake_wait();
    serial_irq <= 1'b0;
    check(n >= OSC_START_CYC + PLL_LOCK_CYC, 1);
    check(n < OSC_START_CYC + PLL_LOCK_CYC + 20, 1);
    check(wake_irq_service, 1);
    repeat (20) @(posedge clk);
    check(wake_irq_service, 0);
    done("power-down serial");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h12);
    serial_irq <= 1'b1;
    repeat (50) @(posedge clk);
    rd(4'h2, 8'h02);
    check(osc_enable, 1);
    interval_counter_irq <= 1'b1;
    wake_wait();
    interval_counter_irq <= 1'b0;
    serial_irq <= 1'b0;
    check(n >= PLL_LOCK_CYC, 1);
    done("power-down interval counter");
    wr(4'h0, 8'h0a);
    repeat (40) @(posedge clk);
    ext0_req <= 1'b1;
    wake_wait();
    ext0_req <= 1'b0;
    check(wake_irq_service, 1);
    rd(4'h3, 8'h02);
    done("power-down ext0");
    repeat (20) @(posedge clk);
    wr(4'h0, 8'h02);
    ext0_req <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h3, 8'h06);
    ext0_req <= 1'b0;
    do_reset();
    rd(4'h0, 8'h00);
    done("reset in power-down");
    wrap_up();
  end
endmodule
